// file: common/rtu_regs.vh
// rtu_regs.vh: constants for the register transfer unit.
// assumes big-endian bit numbering of the instruction halfword (bit 0 = msb).
`ifndef RTU_REGS_VH
`define RTU_REGS_VH

// instruction fields, expressed as verilog indices of a [15:0] halfword
`define RTU_OP_HI 15
`define RTU_OP_LO 10
`define RTU_RD_HI 9
`define RTU_RD_LO 7
`define RTU_RS_HI 6
`define RTU_RS_LO 4
`define RTU_AUG_HI 3
`define RTU_AUG_LO 0
`define RTU_PR_HI 6
`define RTU_PR_LO 3
// general register of the protect opcodes, halfword bits 13-15
`define RTU_PG_HI 2
`define RTU_PG_LO 0
// page of a store within its module, and the protect bit of page 0
`define RTU_PAGE_HI 6
`define RTU_PAGE_LO 3
`define RTU_PAGE_TOP 4'hF
// register file sizes and the selector field of GPR_SEL
`define RTU_NGPR 8
`define RTU_NPROT 16
`define RTU_SEL_HI 2
// primary opcodes (top six bits)
`define RTU_OP_XFER 6'h0B
`define RTU_OP_PROT 6'h3E
// augmenting codes
`define RTU_AUG_MOVE 4'h0
`define RTU_AUG_NEG 4'h4
`define RTU_AUG_MASK 4'h8
`define RTU_AUG_SCR_RD 4'h2
`define RTU_AUG_SCR_WR 4'hE
// bit 8 of the protect opcodes picks the direction
`define RTU_PROT_DIR 7
`define RTU_MASK_REG 3'h4
// scratchpad address field of a general register, word bits 8-15
`define RTU_SP_HI 23
`define RTU_SP_LO 16
`define RTU_SP_DEPTH 256
// protect register occupies word bits 16-31
`define RTU_PR_W 16
`define RTU_PC_STEP 24'h000002
`define RTU_PC_RST 24'h000000
// AXI4-Lite register map (byte addresses)
`define RTU_A_INSTR 4'h0
`define RTU_A_GPR_SEL 4'h4
`define RTU_A_GPR_DAT 4'h8
`define RTU_A_STATUS 4'hC
`define RTU_RESP_OKAY 2'b00
`define RTU_RESP_SLVERR 2'b10
// status register fields
`define RTU_ST_CC_LO 0
`define RTU_ST_PRIV 4
`define RTU_ST_TRAP 5
`define RTU_ST_ILL 6
`define RTU_ST_PC_LO 8
`endif

// file: core/rtu_core.v
// rtu_core.v: register transfer group decoder and executor.
// assumes an AXI4-Lite master issues instructions; one per write to INSTR.
// Notes on behaviour
// (RULE_01) instruction bits 0-5 give the primary opcode.
// (RULE_02) bits 6-8 pick the destination general register.
// (RULE_03) bits 9-11 pick the source general register.
// (RULE_04) bits 12-15 are the augmenting opcode within one primary opcode.
// (RULE_05) plain move copies the source word unchanged to destination.
// (RULE_06) move and masked move clear cc1; cc2-4 show positive, negative, zero.
// (RULE_07) masked move ands source with register 4 into destination.
// (RULE_08) negate move writes two's complement; cc2-4 reflect the result.
// (RULE_09) negate sets cc1 on overflow, clears it otherwise.
// (RULE_10) scratch read loads word at source bits 8-15; source unchanged.
// (RULE_11) scratch write stores source at destination bits 8-15 address.
// (RULE_12) scratchpad holds 256 words addressed by eight bits.
// (RULE_13) scratchpad transfers are privileged halfword instructions.
// (RULE_14) scratch and protect transfers leave condition codes alone.
// (RULE_15) load-protect writes a general register into protect reg bits 9-12.
// (RULE_16) protect register number equals the module's high address bits.
// (RULE_17) only word bits 16-31 go into the 16-bit protect register.
// (RULE_18) read-protect places protect register in word bits 16-31.
// (RULE_19) unprivileged store into a protected location traps.
// (RULE_20) every completed halfword instruction advances pc by two.
//
// Our own choices: register access over AXI4-Lite and the address map.
`include "rtu_regs.vh"

module rtu_core (
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire privileged,
  input wire [3:0] store_module,
  input wire [6:0] store_page,
  input wire store_req,
  output reg priv_trap
);

  reg [31:0] general_register [0:7];
  reg [31:0] scratch [0:`RTU_SP_DEPTH-1];
  reg [15:0] prot [0:15];
  reg [3:0] cc_reg;
  reg [23:0] pc_reg;
  reg [2:0] sel_reg;
  reg ill_reg;
  reg [3:0] aw_addr_reg;
  reg aw_have_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg w_have_reg;
  integer i;
  integer j;

  // full and partial strobes alike go through a per-byte merge
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k])
          merge[k*8 +: 8] = nw[k*8 +: 8];
      end
    end
  endfunction

  // cc2..cc4 from a result, cc1 supplied
  function [3:0] cc_of;
    input ovf;
    input [31:0] v;
    begin
      cc_of = {v == 32'h00000000, v[31], ~v[31] && (v != 32'h00000000), ovf};
    end
  endfunction

  // ready is offered only while the enable lets the handshake land;
  // otherwise the master would see a transfer that the block never took
  assign s_axi_awready = clk_en && ~aw_have_reg && ~s_axi_bvalid;
  assign s_axi_wready = clk_en && ~w_have_reg && ~s_axi_bvalid;
  assign s_axi_arready = clk_en && ~s_axi_rvalid;

  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire aw_ok = aw_have_reg || aw_fire;
  wire w_ok = w_have_reg || w_fire;
  wire [3:0] wa = aw_have_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wd = w_have_reg ? w_data_reg : s_axi_wdata;
  wire [3:0] ws = w_have_reg ? w_strb_reg : s_axi_wstrb;
  wire do_wr = aw_ok && w_ok && ~s_axi_bvalid;

  // one write per response, so these strobes last exactly one cycle
  wire ins_go = do_wr && (wa == `RTU_A_INSTR);
  wire sel_poke = do_wr && (wa == `RTU_A_GPR_SEL);
  wire gpr_poke = do_wr && (wa == `RTU_A_GPR_DAT);

  // kinds of executed instruction
  localparam K_MOVE = 3'h0;
  localparam K_MASK = 3'h1;
  localparam K_NEG = 3'h2;
  localparam K_SRD = 3'h3;
  localparam K_SWR = 3'h4;
  localparam K_PLD = 3'h5;
  localparam K_PRD = 3'h6;
  localparam K_BAD = 3'h7;

  // sorts an instruction into one of the kinds above
  function [2:0] kind_of;
    input [5:0] o;
    input [3:0] a;
    input dir;
    begin
      kind_of = K_BAD;
      if (o == `RTU_OP_XFER) begin
        case (a)
          `RTU_AUG_MOVE: kind_of = K_MOVE;
          `RTU_AUG_MASK: kind_of = K_MASK;
          `RTU_AUG_NEG: kind_of = K_NEG;
          `RTU_AUG_SCR_RD: kind_of = K_SRD;
          `RTU_AUG_SCR_WR: kind_of = K_SWR;
          default: kind_of = K_BAD;
        endcase
      end else if (o == `RTU_OP_PROT) begin
        if (dir)
          kind_of = K_PRD;
        else
          kind_of = K_PLD;
      end
    end
  endfunction

  // instruction decode; halfword lives in wd[15:0], msb first
  wire [15:0] ins = wd[15:0];
  wire [5:0] op = ins[`RTU_OP_HI:`RTU_OP_LO]; // RULE_01
  wire [2:0] rd = ins[`RTU_RD_HI:`RTU_RD_LO]; // RULE_02
  wire [2:0] rs = ins[`RTU_RS_HI:`RTU_RS_LO]; // RULE_03
  wire [3:0] aug = ins[`RTU_AUG_HI:`RTU_AUG_LO]; // RULE_04
  wire [3:0] prn = ins[`RTU_PR_HI:`RTU_PR_LO]; // RULE_15
  // the protect opcodes name their register after the protect field
  wire [2:0] pg = ins[`RTU_PG_HI:`RTU_PG_LO]; // RULE_15
  wire [31:0] src = general_register[rs];
  wire [31:0] dst = general_register[rd];
  wire [31:0] pg_word = general_register[pg];
  wire [31:0] masked = src & general_register[`RTU_MASK_REG]; // RULE_07
  wire [31:0] neg = 32'h00000000 - src;
  // only the most negative word has no positive counterpart
  wire neg_ovf = (src == 32'h80000000); // RULE_09
  wire [2:0] kind = kind_of(op, aug, ins[`RTU_PROT_DIR]);

  // effects of the instruction on the bus, applied only on ins_go
  reg ex_gpr_we;
  reg [2:0] ex_gpr_idx;
  reg [31:0] ex_gpr_val;
  reg ex_cc_we;
  reg [3:0] ex_cc_val;
  reg ex_prot_we;
  reg ex_sp_we;
  reg ex_ill;

  always @* begin
    ex_gpr_we = 1'b0;
    ex_gpr_idx = rd;
    ex_gpr_val = src;
    ex_cc_we = 1'b0;
    ex_cc_val = cc_reg;
    ex_prot_we = 1'b0;
    ex_sp_we = 1'b0;
    ex_ill = 1'b0;
    case (kind)
      K_MOVE: begin
        ex_gpr_we = 1'b1;
        ex_gpr_val = src; // RULE_05
        ex_cc_we = 1'b1;
        ex_cc_val = cc_of(1'b0, src); // RULE_06
      end
      K_MASK: begin
        ex_gpr_we = 1'b1;
        ex_gpr_val = masked; // RULE_07
        ex_cc_we = 1'b1;
        ex_cc_val = cc_of(1'b0, masked); // RULE_06
      end
      K_NEG: begin
        ex_gpr_we = 1'b1;
        ex_gpr_val = neg; // RULE_08
        ex_cc_we = 1'b1;
        ex_cc_val = cc_of(neg_ovf, neg); // RULE_09
      end
      K_SRD: begin
        // unprivileged use is refused; the condition code stays untouched
        ex_gpr_we = privileged; // RULE_13 RULE_14
        ex_gpr_val = scratch[src[`RTU_SP_HI:`RTU_SP_LO]]; // RULE_10
        ex_ill = ~privileged;
      end
      K_SWR: begin
        ex_sp_we = privileged; // RULE_11 RULE_13
        ex_ill = ~privileged;
      end
      K_PLD: begin
        ex_prot_we = 1'b1; // RULE_14 RULE_15
      end
      K_PRD: begin
        ex_gpr_we = 1'b1;
        ex_gpr_idx = pg;
        ex_gpr_val = {16'h0000, prot[prn]}; // RULE_18
      end
      default: begin
        // unknown codes still advance pc, so software can step past them
        ex_ill = 1'b1;
      end
    endcase
  end

  // protect bit of the page being stored to; a set bit opens the page
  wire [3:0] page_idx = store_page[`RTU_PAGE_HI:`RTU_PAGE_LO];
  wire [15:0] store_prot = prot[store_module]; // RULE_16
  wire page_open = store_prot[`RTU_PAGE_TOP - page_idx];
  wire trap_next = store_req && ~privileged && ~page_open; // RULE_19

  // unmapped offsets answer with a slave error on either channel
  function [1:0] addr_resp;
    input [3:0] a;
    begin
      case (a)
        `RTU_A_INSTR: addr_resp = `RTU_RESP_OKAY;
        `RTU_A_GPR_SEL: addr_resp = `RTU_RESP_OKAY;
        `RTU_A_GPR_DAT: addr_resp = `RTU_RESP_OKAY;
        `RTU_A_STATUS: addr_resp = `RTU_RESP_OKAY;
        default: addr_resp = `RTU_RESP_SLVERR;
      endcase
    end
  endfunction

  // read word picked from the address; registered when the read is taken
  reg [31:0] rd_word;

  always @* begin
    rd_word = 32'h00000000;
    case (s_axi_araddr)
      `RTU_A_INSTR: rd_word = 32'h00000000;
      `RTU_A_GPR_SEL: rd_word = {29'h0, sel_reg};
      `RTU_A_GPR_DAT: rd_word = general_register[sel_reg];
      `RTU_A_STATUS: rd_word = {pc_reg, 1'b0, ill_reg, priv_trap,
                                privileged, cc_reg};
      default: rd_word = 32'h00000000;
    endcase
  end

  // bus handshake state and the trap flag
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RTU_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RTU_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      priv_trap <= 1'b0;
    end else if (clk_en) begin
      priv_trap <= trap_next; // RULE_16 RULE_19
      if (aw_fire && !do_wr) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_fire && !do_wr) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_wr) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_resp(wa);
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= addr_resp(s_axi_araddr);
        s_axi_rdata <= rd_word;
      end
    end
  end

  // program counter, condition code, refusal flag and register selector
  always @(posedge aclk) begin
    if (!aresetn) begin
      cc_reg <= 4'h0;
      pc_reg <= `RTU_PC_RST;
      sel_reg <= 3'h0;
      ill_reg <= 1'b0;
    end else if (clk_en) begin
      if (ins_go) begin
        pc_reg <= pc_reg + `RTU_PC_STEP; // RULE_20
        ill_reg <= ex_ill;
        if (ex_cc_we)
          cc_reg <= ex_cc_val; // RULE_06 RULE_14
      end
      if (sel_poke)
        sel_reg <= wd[`RTU_SEL_HI:0];
    end
  end

  // general registers: an executed move or a bus poke, never both at once
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < `RTU_NGPR; i = i + 1)
        general_register[i] <= 32'h00000000;
    end else if (clk_en) begin
      if (ins_go && ex_gpr_we)
        general_register[ex_gpr_idx] <= ex_gpr_val;
      else if (gpr_poke)
        general_register[sel_reg] <= merge(general_register[sel_reg], wd, ws);
    end
  end

  // protect registers, one per memory module
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (j = 0; j < `RTU_NPROT; j = j + 1)
        prot[j] <= 16'h0000;
    end else if (clk_en) begin
      if (ins_go && ex_prot_we)
        prot[prn] <= pg_word[`RTU_PR_W-1:0]; // RULE_15 RULE_17
    end
  end

  // scratchpad kept out of reset so it maps onto block ram
  always @(posedge aclk) begin
    if (clk_en && aresetn && ins_go && ex_sp_we) // RULE_13 RULE_14
      scratch[dst[`RTU_SP_HI:`RTU_SP_LO]] <= src; // RULE_11 RULE_12
  end

endmodule // rtu_core

// file: testbench/rtu_core_checker.sv
// rtu_core_checker.sv: bus handshake and trap checks on rtu_core ports.
// assumes one aclk domain; aresetn is synchronous and active low.
module rtu_core_checker (
  input logic aclk,
  input logic aresetn,
  input logic clk_en,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic privileged,
  input logic store_req,
  input logic priv_trap
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  wr_answer_a: assert property (clk_en && s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
  rd_answer_a: assert property (clk_en && s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no rvalid");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready
    && !s_axi_wready) else $error("write taken during response");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  trap_cause_a: assert property (priv_trap |-> $past(store_req)
    && !$past(privileged)) else $error("trap without unprivileged store");
  trap_priv_a: assert property (store_req && privileged |=> !priv_trap)
    else $error("trap on privileged store");
endmodule // rtu_core_checker

bind rtu_core rtu_core_checker chk_i (.aclk, .aresetn, .clk_en,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .privileged, .store_req, .priv_trap);

// file: testbench/rtu_core_tb.sv
// rtu_core_tb.sv: instruction tests issued over the AXI4-Lite port.
// assumes map INSTR 0x0, GPR_SEL 0x4, GPR_DAT 0x8, STATUS 0xC.
module rtu_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, privileged = 1'b1;
  logic store_req = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, store_module = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [6:0] store_page = 7'h00;
  logic [31:0] s_axi_wdata = 32'h0, v;
  logic [23:0] pc_exp = 24'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, priv_trap;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [1:0] resp;
  int checks = 0, miscompares = 0;
  rtu_core DUT (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .privileged, .store_module, .store_page, .store_req, .priv_trap);
  initial begin
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // both halves offered together; each released at its own ready
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task automatic ex(input logic [15:0] i);
    wr(4'h0, {16'h0000, i});
    pc_exp += 24'h000002;
  endtask
  task automatic sg(input logic [2:0] r, input logic [31:0] d);
    wr(4'h4, {29'h0, r});
    wr(4'h8, d);
  endtask
  task automatic gc(input logic [2:0] r, input logic [31:0] e);
    wr(4'h4, {29'h0, r});
    rd(4'h8, v);
    chk(e, v);
  endtask
  // flag bits 7:4 are left out; cc and pc are compared
  task automatic sc(input logic [3:0] cc);
    rd(4'hC, v);
    chk({pc_exp, 4'h0, cc}, {v[31:8], 4'h0, v[3:0]});
  endtask
  task automatic tr(input logic [3:0] m, input logic [6:0] p,
    input logic pv, input logic e);
    @(posedge aclk);
    store_module <= m;
    store_page <= p;
    privileged <= pv;
    store_req <= 1'b1;
    @(posedge aclk);
    store_req <= 1'b0;
    @(posedge aclk);
    chk({31'h0, e}, {31'h0, priv_trap});
    privileged <= 1'b1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    sc(4'h0);
    wr(4'h2, 32'h00002C00);
    chk(32'h2, {30'h0, resp});
    rd(4'h2, v);
    chk(32'h2, {30'h0, resp});
    sc(4'h0);
    sg(3'h2, 32'h000803AB);
    ex(16'h2CA0);
    gc(3'h1, 32'h000803AB);
    sc(4'h2);
    sg(3'h4, 32'h0007FFFF);
    ex(16'h2CA8);
    gc(3'h1, 32'h000003AB);
    sg(3'h6, 32'h00000FFF);
    ex(16'h2FE4);
    gc(3'h7, 32'hFFFFF001);
    sc(4'h4);
    sg(3'h6, 32'h80000000);
    ex(16'h2FE4);
    sc(4'h5);
    ex(16'h2CE0);
    sc(4'h4);
    sg(3'h3, 32'h12FF3456);
    sg(3'h5, 32'hCAFE0001);
    ex(16'h2DDE);
    ex(16'h2F32);
    gc(3'h6, 32'hCAFE0001);
    gc(3'h3, 32'h12FF3456);
    sc(4'h4);
    privileged <= 1'b0;
    ex(16'h2D9E);
    rd(4'hC, v);
    chk(32'h2, {30'h0, v[6], v[4]});
    privileged <= 1'b1;
    ex(16'h2F32);
    gc(3'h6, 32'hCAFE0001);
    sg(3'h7, 32'hABCD8001);
    ex(16'hFB77);
    sg(3'h7, 32'h00000000);
    ex(16'hFBF7);
    gc(3'h7, 32'h00008001);
    sc(4'h4);
    tr(4'hE, 7'h00, 1'b0, 1'b0);
    tr(4'hE, 7'h08, 1'b0, 1'b1);
    tr(4'hE, 7'h78, 1'b0, 1'b0);
    tr(4'hE, 7'h08, 1'b1, 1'b0);
    tr(4'h1, 7'h00, 1'b0, 1'b1);
    sg(3'h2, 32'h5555AAAA);
    ex(16'hFB0A);
    ex(16'hFB8D);
    gc(3'h5, 32'h0000AAAA);
    tr(4'h1, 7'h00, 1'b0, 1'b0);
    tr(4'h1, 7'h08, 1'b0, 1'b1);
    tally_and_finish;
  end
endmodule // rtu_core_tb
